// File: logic/mph_params.sv
`timescale 1ns/100ps
`include "mph_defs.svh"

// What this block does
// - Position profile accelerates at accel rate
// - Position profile decelerates at decel rate
// - Quick stop option 2/5 uses stop decel
// - Torque reference rate limited by slope
// - Torque stop options ramp at slope rate
// - Slope clamped to torque reference limit
// - Numerator 1..max, default 1, stopped only
// - Motor position is load position times ratio
// - Motor rpm from speed, numerator, 60, resolution
// - Motor accel uses numerator, 1000, resolution, 60
// - Denominator 1..max, default 1, stopped only
// - Homing selector signed, -3..35, default 1
// - Methods 15,16,31,32 do no homing
// - -3 nearby index; 33 reverse, 34 forward
// - -2/-1 mechanical limits, index as home
// - 1/2 limit switch falling edge first
// - 3..8,11,12 home switch same side edge
// - 9,10 forward, other side edge
// - 13,14 reverse, index beyond other side
// - 17..30 home at deceleration point
// - Method 35 takes current position home
module mph_params (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                motorStopped,
  input  wire logic                decelPhase,
  input  wire logic signed [31:0]  loadPos,
  input  wire logic [31:0]         loadSpeed,
  input  wire logic [31:0]         loadAccel,
  output logic      [31:0]         rampRate,
  output logic      [31:0]         torqueSlope,
  output logic                     torqueStop,
  output logic signed [31:0]       motorPos,
  output logic      [31:0]         motorSpeed,
  output logic      [31:0]         motorAccel,
  output mph_pkg::mph_home_t       homeCfg
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Scaled quotient, a zero divisor gives zero
  function automatic logic [31:0] mphScale(
    input logic [79:0] prod,
    input logic [39:0] div
  );
    logic [79:0] q;
    q = '0;
    if (div != 40'h00_0000_0000) begin
      q = prod / {40'h00_0000_0000, div};
    end
    return q[31:0];
  endfunction : mphScale

  // Homing method decode
  function automatic mph_pkg::mph_home_t mphDecode(
    input logic signed [15:0] m
  );
    mph_pkg::mph_home_t h;
    logic signed [15:0] b;
    h = '0;
    h.decSrc = mph_pkg::DEC_NONE;
    b = m;
    if (m >= 16'sd17 && m <= 16'sd32) begin
      b = m - 16'sd16;
      h.homeAtDec = 1'b1;
    end
    unique case (b)
      -16'sd3: begin
        h.valid = 1'b1;
        h.nearby = 1'b1;
      end
      -16'sd2, -16'sd1: begin
        h.valid = 1'b1;
        h.forward = (b == -16'sd2);
        h.decSrc = mph_pkg::DEC_MECH;
      end
      16'sd1, 16'sd2: begin
        h.valid = 1'b1;
        h.forward = (b == 16'sd2);
        h.decSrc = mph_pkg::DEC_LIMSW;
        h.needEdge = 1'b1;
      end
      16'sd3, 16'sd4, 16'sd5, 16'sd6,
      16'sd7, 16'sd8, 16'sd11, 16'sd12: begin
        h.valid = 1'b1;
        h.decSrc = mph_pkg::DEC_HOMESW;
        h.needEdge = 1'b1;
        h.edgeRise = !(b == 16'sd3 || b == 16'sd5 ||
                       b == 16'sd7 || b == 16'sd11);
        h.forward = (b == 16'sd3 || b == 16'sd4 ||
                     b == 16'sd7 || b == 16'sd8);
      end
      16'sd9, 16'sd10, 16'sd13, 16'sd14: begin
        h.valid = 1'b1;
        h.decSrc = mph_pkg::DEC_HOMESW;
        h.needEdge = 1'b1;
        h.edgeOther = 1'b1;
        h.edgeRise = (b == 16'sd9 || b == 16'sd13);
        h.forward = (b == 16'sd9 || b == 16'sd10);
      end
      16'sd33, 16'sd34: begin
        h.valid = !h.homeAtDec;
        h.forward = (b == 16'sd34);
      end
      16'sd35: begin
        h.valid = 1'b1;
        h.hereHome = 1'b1;
      end
      default: begin
        h = '0;
      end
    endcase
    return h;
  endfunction : mphDecode

  // ****************************************
  // Register storage
  // ****************************************

  logic [31:0]        accelRate;
  logic [31:0]        decelRate;
  logic [31:0]        estopDecel;
  logic [31:0]        rampSlope;
  logic signed [15:0] homingMethod;
  logic [31:0]        gearNum;
  logic [31:0]        gearDen;
  mph_pkg::mph_ctrl_t ctrl;
  logic [15:0]        torqueLimit;
  logic [31:0]        encRes;
  logic               refusedWr;

  // ****************************************
  // APB decode
  // ****************************************

  // Word index from the byte address
  wire        aligned  = (paddr[1:0] == 2'b00);
  wire [15:0] idx      = {2'b00, paddr[15:2]};
  wire        access   = psel && penable && ce;
  wire        wrEn     = access && pwrite;
  wire        hitAccel = aligned && idx == `MPH_IDX_ACCEL;
  wire        hitDecel = aligned && idx == `MPH_IDX_DECEL;
  wire        hitEstop = aligned && idx == `MPH_IDX_ESTOP;
  wire        hitSlope = aligned && idx == `MPH_IDX_TSLOPE;
  wire        hitHome  = aligned && idx == `MPH_IDX_HOMING;
  wire        hitNum   = aligned && idx == `MPH_IDX_GEARNUM;
  wire        hitDen   = aligned && idx == `MPH_IDX_GEARDEN;
  wire        hitCtrl  = aligned && idx == `MPH_IDX_CTRL;
  wire        hitLim   = aligned && idx == `MPH_IDX_TLIMIT;
  wire        hitEnc   = aligned && idx == `MPH_IDX_ENCRES;
  wire        hitStat  = aligned && idx == `MPH_IDX_STATUS;
  wire        mapped   = hitAccel || hitDecel || hitEstop || hitSlope
                      || hitHome || hitNum || hitDen || hitCtrl
                      || hitLim || hitEnc || hitStat;

  // Value checks on writes
  wire signed [15:0] wrHome  = pwdata[15:0];
  wire               homeOk  = wrHome >= `MPH_HOME_MIN
                            && wrHome <= `MPH_HOME_MAX;
  wire               gearOk  = motorStopped && pwdata != 32'h0000_0000;
  wire               badWr   = (hitHome && !homeOk)
                            || ((hitNum || hitDen) && !gearOk)
                            || hitStat;
  wire               doWr    = wrEn && mapped && !badWr;

  // Zero wait states; frozen while clock enable is low
  assign pready  = ce;
  assign pslverr = psel && penable && (!mapped || (pwrite && badWr));

  // Read mux, narrow fields zero extended
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hitAccel) next_prdata = accelRate;
    if (hitDecel) next_prdata = decelRate;
    if (hitEstop) next_prdata = estopDecel;
    if (hitSlope) next_prdata = rampSlope;
    if (hitHome)  next_prdata = {16'h0000, homingMethod};
    if (hitNum)   next_prdata = gearNum;
    if (hitDen)   next_prdata = gearDen;
    if (hitCtrl)  next_prdata = {21'h00_0000, ctrl};
    if (hitLim)   next_prdata = {16'h0000, torqueLimit};
    if (hitEnc)   next_prdata = encRes;
    if (hitStat)  next_prdata = {26'h000_0000, refusedWr, torqueStop,
                                 homeCfg.valid, motorStopped,
                                 decelPhase, ctrl.quickStopCmd};
  end

  // ****************************************
  // Register writes
  // ****************************************

  // Profile rates and torque slope
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accelRate  <= `MPH_RST_ACCEL;
      decelRate  <= `MPH_RST_DECEL;
      estopDecel <= `MPH_RST_ESTOP;
      rampSlope  <= `MPH_RST_TSLOPE;
    end else if (doWr) begin
      if (hitAccel) accelRate <= pwdata;
      if (hitDecel) decelRate <= pwdata;
      if (hitEstop) estopDecel <= pwdata;
      if (hitSlope) rampSlope <= pwdata;
    end
  end

  // Gear pair, writable only with the motor stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gearNum <= `MPH_RST_GEAR;
      gearDen <= `MPH_RST_GEAR;
    end else if (doWr) begin
      if (hitNum) gearNum <= pwdata;
      if (hitDen) gearDen <= pwdata;
    end
  end

  // Homing selector may change at any time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      homingMethod <= `MPH_RST_HOMING;
    end else if (doWr && hitHome) begin
      homingMethod <= wrHome;
    end
  end

  // Control, torque limit and encoder resolution
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl        <= '0;
      torqueLimit <= `MPH_RST_TLIMIT;
      encRes      <= `MPH_RST_ENCRES;
    end else if (doWr) begin
      if (hitCtrl) ctrl <= pwdata[10:0];
      if (hitLim)  torqueLimit <= pwdata[15:0];
      if (hitEnc)  encRes <= pwdata;
    end
  end

  // Sticky refused write, set wins over the clear
  wire clrRefused = wrEn && hitCtrl && pwdata[31];
  wire setRefused = wrEn && mapped && badWr;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refusedWr <= 1'b0;
    end else if (setRefused) begin
      refusedWr <= 1'b1;
    end else if (clrRefused) begin
      refusedWr <= 1'b0;
    end
  end

  // Read data taken in the setup phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // Ramp selection
  // ****************************************

  // Quick stop deceleration only for options 2 and 5
  wire qsRamp = ctrl.quickStopCmd
             && (ctrl.estopOpt == 4'h2 || ctrl.estopOpt == 4'h5);
  wire [31:0] next_rampRate = qsRamp     ? estopDecel
                            : decelPhase ? decelRate
                            : accelRate;

  // Slope never exceeds the torque reference limit
  wire [31:0] limWide = {16'h0000, torqueLimit};
  wire [31:0] next_torqueSlope = (rampSlope > limWide)
                               ? limWide : rampSlope;

  // Torque mode stop ramps at the slope rate
  wire qsOptT = ctrl.estopOpt == 4'h1 || ctrl.estopOpt == 4'h2
             || ctrl.estopOpt == 4'h5 || ctrl.estopOpt == 4'h6;
  wire hOptT  = ctrl.haltOpt == 4'h1 || ctrl.haltOpt == 4'h2;
  wire next_torqueStop = ctrl.torqueMode
                      && ((ctrl.quickStopCmd && qsOptT)
                       || (ctrl.haltCmd && hOptT));

  // ****************************************
  // Gear conversions
  // ****************************************

  // Magnitude path keeps the division unsigned
  wire        posNeg = loadPos[31];
  wire [31:0] posMag = posNeg ? 32'(-loadPos) : loadPos;
  wire [79:0] posProd = {16'h0000, 64'(posMag) * 64'(gearNum)};
  wire [31:0] posQ = mphScale(posProd, {8'h00, gearDen});
  wire signed [31:0] next_motorPos = posNeg ? -$signed(posQ)
                                            : $signed(posQ);

  // Speed in rpm; products wider than 80 bits cannot occur
  wire [79:0] spdProd = {16'h0000, 64'(loadSpeed) * 64'(gearNum)};
  wire [79:0] spdProd60 = 80'(spdProd * `MPH_SEC_PER_MIN);
  wire [31:0] next_motorSpeed = mphScale(spdProd60,
                                         {8'h00, encRes});

  // Accel in rpm per ms, both divisors applied at once
  wire [79:0] accProd = {16'h0000, 64'(loadAccel) * 64'(gearNum)};
  wire [79:0] accProdK = 80'(accProd * `MPH_MS_PER_SEC);
  wire [39:0] accDiv = 40'({8'h00, encRes} * `MPH_SEC_PER_MIN);
  wire [31:0] next_motorAccel = mphScale(accProdK, accDiv);

  // ****************************************
  // Output registers
  // ****************************************

  // Ramp, slope, stop and homing outputs refreshed each enabled cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rampRate    <= `MPH_RST_ACCEL;
      torqueSlope <= 32'h0000_0000;
      torqueStop  <= 1'b0;
      homeCfg     <= '0;
    end else if (ce) begin
      rampRate    <= next_rampRate;
      torqueSlope <= next_torqueSlope;
      torqueStop  <= next_torqueStop;
      homeCfg     <= mphDecode(homingMethod);
    end
  end

  // Conversion results
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      motorPos   <= 32'sh0000_0000;
      motorSpeed <= 32'h0000_0000;
      motorAccel <= 32'h0000_0000;
    end else if (ce) begin
      motorPos   <= next_motorPos;
      motorSpeed <= next_motorSpeed;
      motorAccel <= next_motorAccel;
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  accel_select_a : assert property (
    ce && !qsRamp && !decelPhase |=> rampRate == $past(accelRate))
    else $error("ramp not at accel rate");

  decel_select_a : assert property (
    ce && !qsRamp && decelPhase |=> rampRate == $past(decelRate))
    else $error("ramp not at decel rate");

  qstop_select_a : assert property (
    ce && ctrl.quickStopCmd && ctrl.estopOpt == 4'h5
    |=> rampRate == $past(estopDecel))
    else $error("quick stop decel not used");

  slope_clamp_a : assert property (
    ce ##1 ce |-> torqueSlope <= {16'h0000, $past(torqueLimit)})
    else $error("slope above torque limit");

  torque_stop_a : assert property (
    ce && ctrl.torqueMode && ctrl.haltCmd && ctrl.haltOpt == 4'h2
    |=> torqueStop)
    else $error("torque halt not ramped");

  num_lock_a : assert property (
    !motorStopped && wrEn && hitNum |=> $stable(gearNum))
    else $error("numerator changed while moving");

  den_zero_a : assert property (
    gearDen != 32'h0000_0000 && gearNum != 32'h0000_0000)
    else $error("gear term zero");

  home_range_a : assert property (
    homingMethod >= `MPH_HOME_MIN && homingMethod <= `MPH_HOME_MAX)
    else $error("homing selector out of range");

  home_void_a : assert property (
    ce && (homingMethod == 16'sd15 || homingMethod == 16'sd16
        || homingMethod == 16'sd31 || homingMethod == 16'sd32)
    |=> !homeCfg.valid)
    else $error("void method reported valid");

  home_here_a : assert property (
    ce && homingMethod == 16'sd35 |=> homeCfg.hereHome && homeCfg.valid)
    else $error("method 35 not current position");

endmodule : mph_params

// File: logic/mph_defs.svh
`ifndef MPH_DEFS_SVH
`define MPH_DEFS_SVH
// Register indices, byte address is four times the index
`define MPH_IDX_ACCEL    16'h3588
`define MPH_IDX_DECEL    16'h358A
`define MPH_IDX_ESTOP    16'h358C
`define MPH_IDX_TSLOPE   16'h3590
`define MPH_IDX_HOMING   16'h35B2
`define MPH_IDX_GEARNUM  16'h3714
`define MPH_IDX_GEARDEN  16'h3814
`define MPH_IDX_CTRL     16'h3900
`define MPH_IDX_TLIMIT   16'h3901
`define MPH_IDX_ENCRES   16'h3902
`define MPH_IDX_STATUS   16'h3903
// Reset values
`define MPH_RST_ACCEL    32'h5355_5555
`define MPH_RST_DECEL    32'h5355_5555
`define MPH_RST_ESTOP    32'h7FFF_FFFF
`define MPH_RST_TSLOPE   32'hFFFF_FFFF
`define MPH_RST_HOMING   16'h0001
`define MPH_RST_GEAR     32'h0000_0001
`define MPH_RST_TLIMIT   16'h0DAC
`define MPH_RST_ENCRES   32'h0080_0000
// Homing selector bounds
`define MPH_HOME_MIN     -16'sd3
`define MPH_HOME_MAX     16'sd35
// Scale factors of the unit conversions
`define MPH_SEC_PER_MIN  40'h00_0000_003C
`define MPH_MS_PER_SEC   80'h0000_0000_0000_0000_03E8
`endif

// File: logic/mph_pkg.sv
package mph_pkg;
  // Deceleration point source of a homing method
  typedef enum logic [1:0] {
    DEC_NONE = 2'b00,
    DEC_MECH = 2'b01,
    DEC_LIMSW = 2'b10,
    DEC_HOMESW = 2'b11
  } mph_dec_t;

  // Decoded homing method
  typedef struct packed {
    logic     valid;
    logic     forward;
    logic     nearby;
    logic     hereHome;
    mph_dec_t decSrc;
    logic     homeAtDec;
    logic     needEdge;
    logic     edgeRise;
    logic     edgeOther;
  } mph_home_t;

  // Software control fields
  typedef struct packed {
    logic       haltCmd;
    logic       quickStopCmd;
    logic       torqueMode;
    logic [3:0] haltOpt;
    logic [3:0] estopOpt;
  } mph_ctrl_t;
endpackage : mph_pkg

// File: sim/mph_host.sv
`timescale 1ns/100ps
// ****************************************
// APB host of the parameter block
// ****************************************
module mph_host (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [15:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
  end

  // One transfer, held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [15:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the bench watchdog ends a dead slave
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines change so stale values cannot pass
    paddr <= ~adr;
    pwdata <= ~wd;
  endtask : xfer
endmodule : mph_host

// File: sim/motion_profile_homing_params_bench.sv
`timescale 1ns/100ps
`include "mph_defs.svh"
// ****************************************
// Bench of the motion parameter block
// ****************************************
module motion_profile_homing_params_bench;
  logic               clk;
  logic               reset_n;
  logic               ce;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [15:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               motorStopped;
  logic               decelPhase;
  logic signed [31:0] loadPos;
  logic [31:0]        loadSpeed;
  logic [31:0]        loadAccel;
  logic [31:0]        rampRate;
  logic [31:0]        torqueSlope;
  logic               torqueStop;
  logic signed [31:0] motorPos;
  logic [31:0]        motorSpeed;
  logic [31:0]        motorAccel;
  mph_pkg::mph_home_t homeCfg;
  int                 fails;
  int                 cmp_count;

  mph_params i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .motorStopped(motorStopped), .decelPhase(decelPhase),
    .loadPos(loadPos), .loadSpeed(loadSpeed), .loadAccel(loadAccel), .rampRate(rampRate),
    .torqueSlope(torqueSlope), .torqueStop(torqueStop), .motorPos(motorPos),
    .motorSpeed(motorSpeed), .motorAccel(motorAccel), .homeCfg(homeCfg));

  mph_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic bad);
    logic [31:0] r;
    logic        e;
    i_host.xfer(1'b1, {idx[13:0], 2'b00}, d, r, e);
    chk(32'(e), 32'(bad), "write error flag");
  endtask : wr

  task automatic rd(input logic [15:0] adr, input logic [31:0] exp, input logic bad);
    logic [31:0] r;
    logic        e;
    i_host.xfer(1'b0, adr, 32'h0000_0000, r, e);
    chk(r, exp, "read data");
    chk(32'(e), 32'(bad), "read error flag");
  endtask : rd

  // Outputs lag one enabled edge; sample away from the edge
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd({`MPH_IDX_ACCEL, 2'b00}, `MPH_RST_ACCEL, 1'b0);
    rd({`MPH_IDX_DECEL, 2'b00}, `MPH_RST_DECEL, 1'b0);
    rd({`MPH_IDX_ESTOP, 2'b00}, 32'h7FFF_FFFF, 1'b0);
    rd({`MPH_IDX_TSLOPE, 2'b00}, 32'hFFFF_FFFF, 1'b0);
    rd({`MPH_IDX_HOMING, 2'b00}, 32'h0000_0001, 1'b0);
    rd({`MPH_IDX_GEARNUM, 2'b00}, 32'h0000_0001, 1'b0);
    rd({`MPH_IDX_GEARDEN, 2'b00}, 32'h0000_0001, 1'b0);
    rd(16'h0000, 32'h0000_0000, 1'b1);
    rd(16'hD621, 32'h0000_0000, 1'b1);
    settle();
    chk(rampRate, 32'h5355_5555, "default ramp");
    chk(torqueSlope, 32'h0000_0DAC, "default slope clamp");
  endtask : t_reset

  task automatic t_ramp();
    wr(`MPH_IDX_ACCEL, 32'h0000_1111, 1'b0);
    wr(`MPH_IDX_DECEL, 32'h0000_2222, 1'b0);
    wr(`MPH_IDX_ESTOP, 32'h0000_3333, 1'b0);
    @(posedge clk);
    decelPhase <= 1'b1;
    settle();
    chk(rampRate, 32'h0000_2222, "decel ramp");
    @(posedge clk);
    decelPhase <= 1'b0;
    // Stop options 0 to 7 with torque mode and the stop command
    for (int o = 0; o < 8; o++) begin
      wr(`MPH_IDX_CTRL, 32'h0000_0300 | 32'(o), 1'b0);
      settle();
      chk(rampRate, (o == 2 || o == 5) ? 32'h0000_3333 : 32'h0000_1111, "stop ramp");
      chk(32'(torqueStop), 32'(o inside {1, 2, 5, 6}), "torque stop");
    end
    for (int h = 0; h < 4; h++) begin
      wr(`MPH_IDX_CTRL, 32'h0000_0500 | 32'(h << 4), 1'b0);
      settle();
      chk(32'(torqueStop), 32'(h inside {1, 2}), "halt stop");
    end
    wr(`MPH_IDX_CTRL, 32'h0000_0201, 1'b0);
    settle();
    chk(32'(torqueStop), 32'h0000_0000, "no torque mode");
    wr(`MPH_IDX_CTRL, 32'h0000_0000, 1'b0);
  endtask : t_ramp

  task automatic t_slope();
    wr(`MPH_IDX_TSLOPE, 32'h0000_0DAD, 1'b0);
    settle();
    chk(torqueSlope, 32'h0000_0DAC, "slope above limit");
    wr(`MPH_IDX_TSLOPE, 32'h0000_0DAB, 1'b0);
    settle();
    chk(torqueSlope, 32'h0000_0DAB, "slope below limit");
    wr(`MPH_IDX_TLIMIT, 32'h0000_0100, 1'b0);
    settle();
    chk(torqueSlope, 32'h0000_0100, "lowered limit");
  endtask : t_slope

  task automatic t_gear();
    @(posedge clk);
    motorStopped <= 1'b0;
    wr(`MPH_IDX_GEARNUM, 32'h0000_0003, 1'b1);
    @(posedge clk);
    motorStopped <= 1'b1;
    wr(`MPH_IDX_GEARNUM, 32'h0000_0000, 1'b1);
    rd({`MPH_IDX_GEARNUM, 2'b00}, 32'h0000_0001, 1'b0);
    wr(`MPH_IDX_GEARNUM, 32'h0000_0003, 1'b0);
    wr(`MPH_IDX_GEARDEN, 32'h0000_0000, 1'b1);
    wr(`MPH_IDX_GEARDEN, 32'h0000_0002, 1'b0);
    wr(`MPH_IDX_ENCRES, 32'h0000_0258, 1'b0);
    @(posedge clk);
    loadPos <= 32'hFFFF_FFF9;
    loadSpeed <= 32'h0000_0064;
    loadAccel <= 32'h0000_03E8;
    settle();
    chk(motorPos, 32'hFFFF_FFF6, "motor position");
    chk(motorSpeed, 32'h0000_001E, "motor speed");
    chk(motorAccel, 32'h0000_0053, "motor accel");
    // Refused gear writes leave the sticky flag set until cleared
    rd({`MPH_IDX_STATUS, 2'b00}, 32'h0000_002C, 1'b0);
    wr(`MPH_IDX_CTRL, 32'h8000_0000, 1'b0);
    rd({`MPH_IDX_STATUS, 2'b00}, 32'h0000_000C, 1'b0);
  endtask : t_gear

  task automatic t_home();
    int   b;
    logic ok;
    for (int m = -4; m <= 36; m++) begin
      ok = (m >= -3 && m <= 35);
      wr(`MPH_IDX_HOMING, {16'h0000, 16'(m)}, !ok);
      if (!ok) continue;
      settle();
      b = (m > 16 && m < 31) ? m - 16 : m;
      chk(32'(homeCfg.valid), 32'(!(m inside {0, 15, 16, 31, 32})), "valid");
      if (m == -3) chk(32'(homeCfg.nearby), 32'h0000_0001, "nearby");
      if (m == 35) chk(32'(homeCfg.hereHome), 32'h0000_0001, "here");
      if (b inside {-2, -1, 1, 2, 33, 34} || (b >= 3 && b <= 14))
        chk(32'(homeCfg.forward), 32'(b inside {-2, 2, 3, 4, 7, 8, 9, 10, 34}), "dir");
      if (b == -2 || b == -1)
        chk(32'(homeCfg.decSrc), 32'(mph_pkg::DEC_MECH), "mech");
      if (b == 1 || b == 2)
        chk(32'(homeCfg.decSrc), 32'(mph_pkg::DEC_LIMSW), "limsw");
      if (b >= 3 && b <= 14)
        chk(32'(homeCfg.decSrc), 32'(mph_pkg::DEC_HOMESW), "homesw");
      if (b >= 9 && b <= 14)
        chk(32'(homeCfg.edgeOther), 32'(b inside {9, 10, 13, 14}), "other side");
      if (b >= 1 && b <= 14) begin
        chk(32'(homeCfg.edgeRise), 32'(b inside {4, 6, 8, 9, 12, 13}), "edge");
        chk(32'(homeCfg.homeAtDec), 32'(b != m), "home at dec");
      end
    end
    rd({`MPH_IDX_HOMING, 2'b00}, 32'h0000_0023, 1'b0);
  endtask : t_home

  // ****************************************
  // Verdict and run control
  // ****************************************
  task automatic close_out();
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Watchdog well beyond the expected run of about five hundred cycles
  initial begin
    #400000;
    fails++;
    close_out();
  end

  // Main sequence
  initial begin
    fails = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    motorStopped = 1'b1;
    decelPhase = 1'b0;
    loadPos = 32'h0000_0000;
    loadSpeed = 32'h0000_0000;
    loadAccel = 32'h0000_0000;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_ramp();
    t_slope();
    t_gear();
    t_home();
    close_out();
  end
endmodule : motion_profile_homing_params_bench
